// File: hw/rtpo_defs.vh
// register map, field positions and reset values of the real-time pattern output port
`ifndef RTPO_DEFS_VH
`define RTPO_DEFS_VH

// register byte addresses on apb
`define RTPO_ADDR_CTRL      12'h000
`define RTPO_ADDR_LOWER     12'h004
`define RTPO_ADDR_UPPER     12'h008
`define RTPO_ADDR_LATCH     12'h00C
`define RTPO_ADDR_DIR       12'h010
`define RTPO_ADDR_BITOP     12'h014
`define RTPO_ADDR_FIFO      12'h018
`define RTPO_ADDR_STATUS    12'h01C

// control register fields
`define RTPO_CTRL_LOWER_EN  0
`define RTPO_CTRL_UPPER_EN  1
`define RTPO_CTRL_BYTE_MODE 2
`define RTPO_CTRL_EXT_SEL   3
`define RTPO_CTRL_EXT_ONLY  4

// bit-op register fields: [2:0] bit index, [8] value
`define RTPO_BITOP_VAL      8

// reset values
`define RTPO_CTRL_RESET     8'h00
`define RTPO_DIR_RESET      8'h00
`define RTPO_LATCH_RESET    8'h00
`define RTPO_STAGE_RESET    8'h00

// fifo depth in words
`define RTPO_FIFO_DEPTH     4

`endif

// File: hw/rtpo_fifo.v
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rtpo_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // fill level
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  integer         i;

  // honest flags straight from the count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign level     = count;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////
  // pointers and count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

  // storage; data words also cleared on reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end else if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // rtpo_fifo

// File: hw/rtpo_port.v
// real-time pattern output port: apb registers, staging fifo, trigger-driven output latch
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "rtpo_defs.vh"
module rtpo_port #(
  parameter FIFO_DEPTH = `RTPO_FIFO_DEPTH,
  parameter FIFO_AW    = 2
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // trigger pulses from the timer, same clock
  input  wire        compare_zero_match,
  input  wire        compare_one_match,
  // external trigger pin, asynchronous
  input  wire        external_pin_event,
  // port pins; enable low means driving
  output reg  [7:0]  port_out,
  output reg  [7:0]  port_oe_n,
  // trigger acknowledge pulses, one per loaded half
  output reg         lower_loaded,
  output reg         upper_loaded
);

  ////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0] realtime_port_control;
  reg  [3:0] upper_nibble_stage;
  reg  [3:0] lower_nibble_stage;
  reg  [7:0] port_output_latch;
  reg  [7:0] port_direction_register;
  reg        ext_meta;
  reg        ext_sync;
  reg        ext_prev;
  reg        stage_pending;

  wire       lower_realtime_enable   = realtime_port_control[`RTPO_CTRL_LOWER_EN];
  wire       upper_realtime_enable   = realtime_port_control[`RTPO_CTRL_UPPER_EN];
  wire       byte_mode               = realtime_port_control[`RTPO_CTRL_BYTE_MODE];
  wire       external_trigger_select = realtime_port_control[`RTPO_CTRL_EXT_SEL];
  wire       external_only_select    = realtime_port_control[`RTPO_CTRL_EXT_ONLY];
  wire       byte_rt = byte_mode & lower_realtime_enable & upper_realtime_enable;

  // apb decode; every access finishes in its first access cycle
  wire       acc     = psel & penable;
  wire       wr      = acc & pwrite;
  wire       hit_ctrl  = (paddr == `RTPO_ADDR_CTRL);
  wire       hit_lower = (paddr == `RTPO_ADDR_LOWER);
  wire       hit_upper = (paddr == `RTPO_ADDR_UPPER);
  wire       hit_latch = (paddr == `RTPO_ADDR_LATCH);
  wire       hit_dir   = (paddr == `RTPO_ADDR_DIR);
  wire       hit_bitop = (paddr == `RTPO_ADDR_BITOP);
  wire       hit_fifo  = (paddr == `RTPO_ADDR_FIFO);
  wire       hit_stat  = (paddr == `RTPO_ADDR_STATUS);
  wire       mapped    = hit_ctrl | hit_lower | hit_upper | hit_latch |
                         hit_dir | hit_bitop | hit_fifo | hit_stat;

  ////////////////////////////////////////////////////////////////////////
  // staging fifo: software queues whole patterns; the next one moves to the stage whenever no popped pattern is pending there and no stage write competes
  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [7:0]       fifo_out_data;
  wire [FIFO_AW:0] fifo_level;
  wire             fifo_push = wr & hit_fifo;
  wire             fifo_pop;

  rtpo_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // external pin: two-flop synchroniser, then rising-edge detect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_pin_event;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  wire ext_edge = ext_sync & ~ext_prev;

  // trigger source for lower nibble or whole byte
  function trig_sel;
    input c0;
    input ext;
    input sel;
    input only;
    begin
      if (!sel)
        trig_sel = c0;
      else if (!only)
        trig_sel = c0 | ext;
      else
        trig_sel = ext;
    end
  endfunction

  wire low_trig = trig_sel(compare_zero_match, ext_edge,
                           external_trigger_select, external_only_select);
  // in byte mode compare-one is not a source; upper rides with lower
  wire load_low = lower_realtime_enable & low_trig;
  wire load_up  = upper_realtime_enable &
                  (byte_mode ? low_trig : compare_one_match);

  // a queued pattern is moved into the stage only when no write competes
  wire stage_wr = wr & (hit_lower | hit_upper);
  assign fifo_pop = fifo_out_valid & ~stage_pending & ~stage_wr;

  ////////////////////////////////////////////////////////////////////////
  // control register: whole-byte writes or single-bit set/clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      realtime_port_control <= `RTPO_CTRL_RESET;
    end else if (wr & hit_ctrl) begin
      realtime_port_control <= pwdata[7:0];
    end else if (wr & hit_bitop) begin
      realtime_port_control[pwdata[2:0]] <= pwdata[`RTPO_BITOP_VAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // staging buffers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_nibble_stage <= 4'h0;
      lower_nibble_stage <= 4'h0;
      stage_pending      <= 1'b0;
    end else begin
      if (stage_wr & byte_rt) begin
        // either address loads both halves as one channel
        upper_nibble_stage <= pwdata[7:4];
        lower_nibble_stage <= pwdata[3:0];
      end else if (stage_wr) begin
        if (hit_upper)
          upper_nibble_stage <= pwdata[7:4];
        if (hit_lower)
          lower_nibble_stage <= pwdata[3:0];
      end else if (fifo_pop) begin
        upper_nibble_stage <= fifo_out_data[7:4];
        lower_nibble_stage <= fifo_out_data[3:0];
      end
      // pending marks a fifo pattern not yet consumed by a trigger
      if (fifo_pop)
        stage_pending <= 1'b1;
      else if (load_low | load_up | stage_wr)
        stage_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output latch: trigger wins for real-time halves, software for ordinary
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch <= `RTPO_LATCH_RESET;
      lower_loaded      <= 1'b0;
      upper_loaded      <= 1'b0;
    end else begin
      lower_loaded <= load_low;
      upper_loaded <= load_up;
      if (load_low)
        port_output_latch[3:0] <= lower_nibble_stage;
      else if (wr & hit_latch & ~lower_realtime_enable)
        port_output_latch[3:0] <= pwdata[3:0];
      if (load_up)
        port_output_latch[7:4] <= upper_nibble_stage;
      else if (wr & hit_latch & ~upper_realtime_enable)
        port_output_latch[7:4] <= pwdata[7:4];
    end
  end

  // direction register: 1 means output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      port_direction_register <= `RTPO_DIR_RESET;
    else if (wr & hit_dir)
      port_direction_register <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers registered; they follow the latch one cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out  <= 8'h00;
      port_oe_n <= 8'hFF;
    end else begin
      port_out <= port_output_latch;
      // real-time enable overrides the direction register
      port_oe_n[3:0] <= lower_realtime_enable ? 4'h0 :
                        ~port_direction_register[3:0];
      port_oe_n[7:4] <= upper_realtime_enable ? 4'h0 :
                        ~port_direction_register[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, error on unmapped or full-fifo write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped |
                 (pwrite & (paddr == `RTPO_ADDR_FIFO) & ~fifo_in_ready));
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        if (hit_ctrl)
          prdata <= {24'h000000, realtime_port_control};
        else if (hit_lower | hit_upper)
          prdata <= {24'h000000, upper_nibble_stage, lower_nibble_stage};
        else if (hit_latch)
          prdata <= {24'h000000, port_output_latch};
        else if (hit_dir)
          prdata <= {24'h000000, port_direction_register};
        else if (hit_stat)
          prdata <= {28'h0000000, stage_pending, fifo_level};
      end
    end
  end

endmodule // rtpo_port

// File: testbench/rtpo_port_sva.sv
// assertion checker for the real-time pattern output port
`timescale 1ns/1ps
`include "rtpo_defs.vh"
module rtpo_port_sva #(
  parameter FIFO_DEPTH = 4
) (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // triggers
  input wire        compare_zero_match,
  input wire        compare_one_match,
  input wire        external_pin_event,
  // pins and acknowledges
  input wire [7:0]  port_out,
  input wire [7:0]  port_oe_n,
  input wire        lower_loaded,
  input wire        upper_loaded
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write as taken in the access cycle
  wire wr_take = psel && penable && pwrite;
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in access cycle");
  AST_APB_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_APB_ACCESS: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // register then pin flop: a change is seen two sampling edges after its cause
  AST_OE_CAUSE: assert property ($changed(port_oe_n) |-> $past(wr_take, 2))
    else $error("drivers changed without write");
  AST_OUT_CAUSE: assert property ($changed(port_out) |->
    $past(lower_loaded || upper_loaded) || $past(wr_take && paddr == `RTPO_ADDR_LATCH, 2))
    else $error("pins changed without cause");
  AST_LOWER_CAUSE: assert property (lower_loaded |-> $past(compare_zero_match) ||
    $past(external_pin_event, 3) || $past(external_pin_event, 4)) else $error("lower load");
  AST_UPPER_CAUSE: assert property (upper_loaded |-> $past(compare_one_match) ||
    lower_loaded) else $error("upper load");
  // main scenarios
  COV_BYTE: cover property (lower_loaded && upper_loaded);
  COV_NIB: cover property (upper_loaded && !lower_loaded);
  COV_ERR: cover property (pslverr);
endmodule // rtpo_port_sva

bind rtpo_port rtpo_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_zero_match(compare_zero_match),
  .compare_one_match(compare_one_match), .external_pin_event(external_pin_event),
  .port_out(port_out), .port_oe_n(port_oe_n), .lower_loaded(lower_loaded),
  .upper_loaded(upper_loaded));

// File: testbench/rtpo_load.sv
// pin load model: coil levels seen on the pins and the external event source
`timescale 1ns/1ps
module rtpo_load (
  // clock
  input  wire       pclk,
  // port pins
  input  wire [7:0] port_out,
  input  wire [7:0] port_oe_n,
  // event request from the bench
  input  wire       fire,
  // coil levels and event pin
  output reg  [7:0] pin_level = 8'h00,
  output reg        external_pin_event = 1'b0
);
  integer hold = 0;
  // released pins toggle so no stale level passes for a driven one
  always @(posedge pclk) begin
    pin_level <= (port_out & ~port_oe_n) | (~pin_level & port_oe_n);
  end
  // event pin held four cycles so the synchroniser surely sees it
  always @(posedge pclk) begin
    hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
    external_pin_event <= fire || hold > 1;
  end
endmodule // rtpo_load

// File: testbench/realtime_pattern_output_port_bench.sv
// self-checking bench: apb driver, integer model and pattern triggers
`timescale 1ns/1ps
`include "rtpo_defs.vh"
module realtime_pattern_output_port_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg         c0 = 0, c1 = 0, fire = 0, er;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd, wd;
  wire [31:0] prdata;
  wire        pready, pslverr, ext, lo_ld, up_ld;
  wire [7:0]  pout, poe_n, pins;
  integer     num_errors = 0, n_compared = 0, seed = 72470;
  integer     ctrl = 0, lo = 0, up = 0, latch = 0, dir = 0, i, m;
  integer     q[$];
  integer     modes[6] = '{0, 8, 24, 4, 12, 28};
  rtpo_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_zero_match(c0), .compare_one_match(c1),
    .external_pin_event(ext), .port_out(pout), .port_oe_n(poe_n), .lower_loaded(lo_ld),
    .upper_loaded(up_ld));
  rtpo_load u_load (.pclk(pclk), .port_out(pout), .port_oe_n(poe_n), .fire(fire),
    .pin_level(pins), .external_pin_event(ext));
  // 50 ns clock
  initial forever #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic [7:0] rtm();
    rtm = {{4{ctrl[1]}}, {4{ctrl[0]}}};
  endfunction
  function automatic bm();
    bm = ctrl[0] && ctrl[1] && ctrl[2];
  endfunction
  task give_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // one apb transfer; model follows accepted writes
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20) begin
        @(posedge pclk);
        t = t + 1;
      end
      if (pready !== 1'b1) begin
        num_errors = num_errors + 1;
        give_verdict;
      end else begin
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && !er) begin
          if (a == `RTPO_ADDR_CTRL) ctrl = d[7:0];
          if (a == `RTPO_ADDR_BITOP) ctrl[d[2:0]] = d[8];
          if (a == `RTPO_ADDR_DIR) dir = d[7:0];
          if (a == `RTPO_ADDR_LATCH) latch = (latch & rtm()) | (d[7:0] & ~rtm());
          lo = (a == `RTPO_ADDR_LOWER || bm() && a == `RTPO_ADDR_UPPER) ? d[3:0] : lo;
          up = (a == `RTPO_ADDR_UPPER || bm() && a == `RTPO_ADDR_LOWER) ? d[7:4] : up;
        end
      end
    end
  endtask
  task rchk(input string name, input [11:0] a, input [31:0] exp);
    begin
      apb(0, a, 0);
      chk(name, rd, exp);
    end
  endtask
  // pins settle one cycle after the latch, coils one more, seen one edge later
  task pins_chk;
    begin
      repeat (3) @(posedge pclk);
      chk("oe_n", poe_n, ~(rtm() | dir[7:0]) & 8'hFF);
      chk("pins", pins & ~poe_n, latch & ~poe_n);
      chk("port_out", pout, latch);
    end
  endtask
  // one trigger pulse of kind k: 0 compare zero, 1 compare one, 2 pin
  task trig(input integer k);
    reg lt;
    integer n, nl, nu;
    begin
      nl = 0;
      nu = 0;
      lt = ctrl[3] ? (ctrl[4] ? k == 2 : k != 1) : k == 0;
      @(posedge pclk);
      c0 <= k == 0;
      c1 <= k == 1;
      fire <= k == 2;
      @(posedge pclk);
      c0 <= 0;
      c1 <= 0;
      fire <= 0;
      if (bm() && lt) latch = up * 16 + lo;
      if (!bm() && ctrl[1] && k == 1) latch = latch % 16 + up * 16;
      if (!bm() && ctrl[0] && lt) latch = latch - latch % 16 + lo;
      // count acknowledge pulses; the pin path lags three edges behind compare
      for (n = 0; n < 5; n = n + 1) begin
        @(posedge pclk);
        nl = nl + lo_ld;
        nu = nu + up_ld;
      end
      chk("lower_loaded", nl, ctrl[0] && lt);
      chk("upper_loaded", nu, ctrl[1] && (bm() ? lt : k == 1));
      pins_chk;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rchk("ctrl", `RTPO_ADDR_CTRL, 8'h00);
    chk("oe_n", poe_n, 8'hFF);
    for (i = 0; i < 10; i = i + 1) begin
      apb(1, `RTPO_ADDR_BITOP, i < 5 ? 256 + i : i - 5);
      rchk("ctrl", `RTPO_ADDR_CTRL, ctrl);
    end
    apb(1, `RTPO_ADDR_LATCH, 8'hA5);
    apb(1, `RTPO_ADDR_CTRL, 8'h03);
    apb(1, `RTPO_ADDR_LOWER, 8'h05);
    apb(1, `RTPO_ADDR_UPPER, 8'hC0);
    rchk("lower", `RTPO_ADDR_LOWER, 8'hC5);
    apb(1, `RTPO_ADDR_LATCH, 8'hFF);
    rchk("latch", `RTPO_ADDR_LATCH, 8'hA5);
    for (m = 1; m < 3; m = m + 1) begin
      apb(1, `RTPO_ADDR_CTRL, m);
      apb(1, `RTPO_ADDR_DIR, $random(seed));
      apb(1, `RTPO_ADDR_LATCH, $random(seed));
      rchk("latch", `RTPO_ADDR_LATCH, latch);
      pins_chk;
    end
    apb(1, `RTPO_ADDR_CTRL, 8'h00);
    apb(1, `RTPO_ADDR_LATCH, 8'h3C);
    pins_chk;
    for (m = 0; m < 18; m = m + 1) begin
      apb(1, `RTPO_ADDR_CTRL, modes[m / 3] + 3);
      apb(1, `RTPO_ADDR_UPPER, $random(seed));
      apb(1, `RTPO_ADDR_LOWER, $random(seed));
      rchk("upper", `RTPO_ADDR_UPPER, up * 16 + lo);
      trig(m % 3);
    end
    apb(0, 12'h020, 0);
    chk("rd", rd, 0);
    chk("err", er, 1);
    // fifo: one word goes to the stages, four wait, the sixth is refused
    apb(1, `RTPO_ADDR_CTRL, 8'h07);
    for (i = 0; i < 6; i = i + 1) begin
      wd = $random(seed) & 32'hFF;
      apb(1, `RTPO_ADDR_FIFO, wd);
      chk("full", er, i == 5);
      if (i < 5) q.push_back(wd);
    end
    rchk("status", `RTPO_ADDR_STATUS, 12);
    while (q.size() > 0) begin
      lo = q[0] % 16;
      up = q.pop_front() / 16;
      trig(0);
    end
    rchk("status", `RTPO_ADDR_STATUS, 0);
    give_verdict;
  end
endmodule // realtime_pattern_output_port_bench
